// file: rtl/ltd_pkg.sv
// constants, opcodes and carrier types of the literal and table instruction decoder
package ltd_pkg;
    // widths
    localparam int W_BITS = 8;
    localparam int BSR_BITS = 6;
    localparam int PTR_BITS = 14;
    localparam int TP_BITS = 21;
    localparam int NUM_PTR = 3;

    // literal instruction upper bytes
    localparam logic [7:0] OP_ADD_LIT = 8'h0f;
    localparam logic [7:0] OP_AND_LIT = 8'h0b;
    localparam logic [7:0] OP_IOR_LIT = 8'h09;
    localparam logic [7:0] OP_XOR_LIT = 8'h0a;
    localparam logic [7:0] OP_SUB_LIT = 8'h08;
    localparam logic [7:0] OP_MOV_LIT = 8'h0e;
    localparam logic [7:0] OP_MUL_LIT = 8'h0d;
    localparam logic [7:0] OP_RET_LIT = 8'h0c;
    localparam logic [7:0] OP_BANK = 8'h01;
    localparam logic [1:0] OP_BANK_PAD = 2'h0;

    // pointer instructions
    localparam logic [7:0] OP_PTR_LONG = 8'hee;
    localparam logic [1:0] OP_PTR_LONG_PAD = 2'h0;
    localparam logic [5:0] OP_PTR_SECOND = 6'h3c;
    localparam logic [7:0] OP_PTR_ADD = 8'he8;
    localparam logic [7:0] OP_PTR_SUB = 8'he9;
    localparam logic [3:0] OP_SECOND_NIB = 4'hf;

    // table instructions: 0x0008..0x000f, bit 2 selects write
    localparam logic [11:0] OP_TBL_HI = 12'h000;
    localparam int TBL_FLAG_BIT = 3;
    localparam int TBL_WRITE_BIT = 2;
    localparam logic [1:0] TBL_MODE_NONE = 2'h0;
    localparam logic [1:0] TBL_MODE_POST_INC = 2'h1;
    localparam logic [1:0] TBL_MODE_POST_DEC = 2'h2;
    localparam logic [1:0] TBL_MODE_PRE_INC = 2'h3;

    // timing in instruction cycles
    localparam int TBL_MIN_CYCLES = 2;
    localparam int TBL_MAX_CYCLES = 5;
    localparam logic [2:0] TBL_WAIT_LIMIT = 3'(TBL_MAX_CYCLES - TBL_MIN_CYCLES);

    // reset values
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [5:0] BSR_RESET = 6'h00;
    localparam logic [13:0] PTR_RESET = 14'h0000;
    localparam logic [20:0] TP_RESET = 21'h000000;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [15:0] PROD_RESET = 16'h0000;

    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } ltd_status_t;

    localparam ltd_status_t STATUS_RESET = 5'h00;

    typedef struct packed {
        logic req;
        logic we;
        logic [20:0] addr;
        logic [7:0] wdata;
    } ltd_pm_req_t;

    localparam ltd_pm_req_t PM_IDLE = 31'h00000000;

    typedef enum logic [2:0] {
        ALU_NONE,
        ALU_ADD,
        ALU_AND,
        ALU_IOR,
        ALU_XOR,
        ALU_SUB,
        ALU_MOV,
        ALU_MUL
    } ltd_alu_op_t;
endpackage

// file: rtl/ltd_lit_alu.sv
// literal-operand arithmetic and logic unit with status flag generation
`timescale 1ns/1ns
module ltd_lit_alu (
    input wire ltd_pkg::ltd_alu_op_t op,
    input wire logic [7:0] w_in,
    input wire logic [7:0] k,
    input wire ltd_pkg::ltd_status_t flags_in,
    output logic [7:0] result,
    output ltd_pkg::ltd_status_t flags_out,
    output logic [15:0] product,
    output logic writes_w
);
    wire [8:0] sum = {1'b0, k} + {1'b0, w_in};
    wire [4:0] sum_lo = {1'b0, k[3:0]} + {1'b0, w_in[3:0]};
    // k - w as k + ~w + 1, carry out means no borrow
    wire [8:0] diff = {1'b0, k} + {1'b0, ~w_in} + 9'h001;
    wire [4:0] diff_lo = {1'b0, k[3:0]} + {1'b0, ~w_in[3:0]} + 5'h01;
    wire ov_add = (k[7] == w_in[7]) && (sum[7] != k[7]);
    wire ov_sub = (k[7] != w_in[7]) && (diff[7] != k[7]);
    wire is_add = op == ltd_pkg::ALU_ADD;
    wire is_sub = op == ltd_pkg::ALU_SUB;
    wire is_arith = is_add || is_sub;
    wire is_logic = (op == ltd_pkg::ALU_AND) || (op == ltd_pkg::ALU_IOR)
        || (op == ltd_pkg::ALU_XOR);

    assign result = is_add ? sum[7:0] : // [RULE1]
        is_sub ? diff[7:0] : // [RULE5]
        (op == ltd_pkg::ALU_AND) ? (k & w_in) : // [RULE2]
        (op == ltd_pkg::ALU_IOR) ? (k | w_in) : // [RULE3]
        (op == ltd_pkg::ALU_XOR) ? (k ^ w_in) : // [RULE4]
        (op == ltd_pkg::ALU_MOV) ? k : w_in; // [RULE6]

    assign product = 16'(k) * 16'(w_in); // [RULE7]
    assign writes_w = (op != ltd_pkg::ALU_NONE) && (op != ltd_pkg::ALU_MUL);

    // moves and multiplies pass the old flags straight through
    assign flags_out.z = (is_arith || is_logic) ? (result == 8'h00) : flags_in.z; // [RULE17]
    assign flags_out.n = (is_arith || is_logic) ? result[7] : flags_in.n; // [RULE17]
    assign flags_out.c = is_add ? sum[8] : is_sub ? diff[8] : flags_in.c;
    assign flags_out.dc = is_add ? sum_lo[4] : is_sub ? diff_lo[4] : flags_in.dc;
    assign flags_out.ov = is_add ? ov_add : is_sub ? ov_sub : flags_in.ov;
endmodule

// file: rtl/ltd_ptr.sv
// one file select pointer with long load and short literal step
`timescale 1ns/1ns
module ltd_ptr #(
    parameter int PTR_BITS = ltd_pkg::PTR_BITS
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic load,
    input wire logic [PTR_BITS-1:0] load_val,
    input wire logic add,
    input wire logic sub,
    input wire logic [5:0] step,
    output logic [PTR_BITS-1:0] value
);
    if (PTR_BITS < 6)
        $error("ltd_ptr: PTR_BITS must be at least 6");

    // step is unsigned, pointer wraps at its own width
    wire [PTR_BITS-1:0] step_ext = PTR_BITS'(step);
    wire [PTR_BITS-1:0] next_value = load ? load_val : // [RULE10]
        add ? PTR_BITS'(value + step_ext) : // [RULE11]
        sub ? PTR_BITS'(value - step_ext) : value; // [RULE12]

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            value <= PTR_BITS'(ltd_pkg::PTR_RESET);
        else if (ce)
            value <= next_value;
    end
endmodule

// file: rtl/ltd_decoder.sv
// literal and table instruction decoder and executor for the 8-bit core
// Contract
// [RULE1] Upper byte 0f adds the literal to the working register in one cycle and sets c, dc, z, ov, n.
// [RULE2] Upper byte 0b ands the literal into the working register in one cycle, touching only z and n.
// [RULE3] Upper byte 09 ors the literal into the working register in one cycle, touching only z and n.
// [RULE4] Upper byte 0a xors the literal into the working register in one cycle, touching only z and n.
// [RULE5] Upper byte 08 puts literal minus working register into it in one cycle, setting all five flags.
// [RULE6] Upper byte 0e loads the literal into the working register in one cycle, flags unchanged.
// [RULE7] Upper byte 0d multiplies literal by working register into the product in one cycle, no flags.
// [RULE8] Upper byte 0c loads the literal, returns from subroutine, takes two cycles, no flags.
// [RULE9] Opcode 01 with literal bits 7:6 zero copies six literal bits into the bank select register.
// [RULE10] The two-word long pointer load writes a 14-bit literal into the chosen pointer over two cycles.
// [RULE11] Upper byte e8 adds a 6-bit unsigned literal to the pointer chosen by bits 7:6 in one cycle.
// [RULE12] Upper byte e9 subtracts a 6-bit literal from the pointer chosen by bits 7:6 in one cycle.
// [RULE13] Opcodes 0008 to 000b read program memory at the table pointer into the latch in 2 to 5 cycles.
// [RULE14] Opcodes 000c to 000f write the latch to program memory at the table pointer in 2 to 5 cycles.
// [RULE15] A second instruction word fetched on its own executes as a no-operation.
// [RULE16] An instruction that changes the program counter spends one extra no-operation cycle.
// [RULE17] Flag-updating instructions set zero for a zero result and copy result bit 7 into negative.
`timescale 1ns/1ns
module ltd_decoder #(
    parameter int NUM_PTR = ltd_pkg::NUM_PTR,
    parameter int PTR_BITS = ltd_pkg::PTR_BITS
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    output logic instr_ready,
    input wire logic tp_load,
    input wire logic [20:0] tp_value,
    input wire logic lat_load,
    input wire logic [7:0] lat_value,
    output ltd_pkg::ltd_pm_req_t pm,
    input wire logic pm_ack,
    input wire logic [7:0] pm_rdata,
    output logic [7:0] working_register,
    output ltd_pkg::ltd_status_t status,
    output logic [5:0] bank_select_register,
    output logic [NUM_PTR-1:0][PTR_BITS-1:0] file_select_pointer,
    output logic [20:0] table_pointer,
    output logic [7:0] table_latch,
    output logic [15:0] product,
    output logic ret_pulse
);
    if (NUM_PTR < 1 || NUM_PTR > 4)
        $error("ltd_decoder: NUM_PTR must lie between 1 and 4");
    if (PTR_BITS != ltd_pkg::PTR_BITS)
        $error("ltd_decoder: long load literal is exactly 14 bits wide");

    typedef enum logic [1:0] {
        ST_EXEC,
        ST_EXTRA,
        ST_PTR_SECOND,
        ST_TABLE
    } ltd_state_t;

    ltd_state_t state;
    ltd_state_t next_state;
    logic [1:0] ptr_sel;
    logic [3:0] ptr_hi;
    logic [2:0] tbl_wait;

    // decode of the presented word
    wire [7:0] op_hi = instr[15:8];
    wire [7:0] op_k = instr[7:0];
    wire take = instr_valid && instr_ready;
    wire is_second_word = instr[15:12] == ltd_pkg::OP_SECOND_NIB;
    // orphan second words match no opcode below and simply retire
    wire exec_now = take && (state == ST_EXEC) && !is_second_word; // [RULE15]
    wire is_ret = op_hi == ltd_pkg::OP_RET_LIT;
    wire is_bank = (op_hi == ltd_pkg::OP_BANK) && (instr[7:6] == ltd_pkg::OP_BANK_PAD);
    wire is_ptr_long = (op_hi == ltd_pkg::OP_PTR_LONG)
        && (instr[7:6] == ltd_pkg::OP_PTR_LONG_PAD);
    wire is_ptr_add = op_hi == ltd_pkg::OP_PTR_ADD;
    wire is_ptr_sub = op_hi == ltd_pkg::OP_PTR_SUB;
    wire is_tbl = (instr[15:4] == ltd_pkg::OP_TBL_HI) && instr[ltd_pkg::TBL_FLAG_BIT];
    wire tbl_write = instr[ltd_pkg::TBL_WRITE_BIT];
    wire [1:0] tbl_mode = instr[1:0];

    ltd_pkg::ltd_alu_op_t alu_op;
    assign alu_op = !exec_now ? ltd_pkg::ALU_NONE :
        (op_hi == ltd_pkg::OP_ADD_LIT) ? ltd_pkg::ALU_ADD :
        (op_hi == ltd_pkg::OP_AND_LIT) ? ltd_pkg::ALU_AND :
        (op_hi == ltd_pkg::OP_IOR_LIT) ? ltd_pkg::ALU_IOR :
        (op_hi == ltd_pkg::OP_XOR_LIT) ? ltd_pkg::ALU_XOR :
        (op_hi == ltd_pkg::OP_SUB_LIT) ? ltd_pkg::ALU_SUB :
        (op_hi == ltd_pkg::OP_MOV_LIT) ? ltd_pkg::ALU_MOV :
        (op_hi == ltd_pkg::OP_MUL_LIT) ? ltd_pkg::ALU_MUL : ltd_pkg::ALU_NONE;

    wire [7:0] alu_result;
    wire [15:0] alu_product;
    wire alu_writes_w;
    ltd_pkg::ltd_status_t alu_flags;

    ltd_lit_alu u_alu (
        .op(alu_op),
        .w_in(working_register),
        .k(op_k),
        .flags_in(status),
        .result(alu_result),
        .flags_out(alu_flags),
        .product(alu_product),
        .writes_w(alu_writes_w)
    );

    // working register, flags, product, bank select
    wire ret_now = exec_now && is_ret;
    wire [7:0] next_w = alu_writes_w ? alu_result :
        ret_now ? op_k : working_register; // [RULE8]
    ltd_pkg::ltd_status_t next_status;
    assign next_status = (alu_op != ltd_pkg::ALU_NONE) ? alu_flags : status;
    wire [15:0] next_product = (alu_op == ltd_pkg::ALU_MUL) ? alu_product : product; // [RULE7]
    wire [5:0] next_bsr = (exec_now && is_bank) ? instr[5:0] : bank_select_register; // [RULE9]

    // pointers: long load finishes on its second word
    wire ptr_long_start = exec_now && is_ptr_long;
    wire ptr_long_done = take && (state == ST_PTR_SECOND)
        && (instr[15:10] == ltd_pkg::OP_PTR_SECOND); // [RULE10]
    wire [PTR_BITS-1:0] ptr_load_val = {ptr_hi, instr[9:0]};
    wire [1:0] ptr_idx = ptr_long_done ? ptr_sel : instr[7:6];
    wire ptr_add = exec_now && is_ptr_add;
    wire ptr_sub = exec_now && is_ptr_sub;

    for (genvar i = 0; i < NUM_PTR; i++)
    begin : g_ptr
        // an index beyond the implemented pointers changes nothing
        wire hit = ptr_idx == 2'(i);
        ltd_ptr #(
            .PTR_BITS(PTR_BITS)
        ) u_ptr (
            .clock(clock),
            .rstn(rstn),
            .ce(ce),
            .load(ptr_long_done && hit),
            .load_val(ptr_load_val),
            .add(ptr_add && hit),
            .sub(ptr_sub && hit),
            .step(instr[5:0]),
            .value(file_select_pointer[i])
        );
    end

    // table access: pointer moves at issue, address already reflects pre-increment
    wire tbl_start = exec_now && is_tbl;
    wire [20:0] tp_inc = 21'(table_pointer + 21'h000001);
    wire [20:0] tp_dec = 21'(table_pointer - 21'h000001);
    wire [20:0] tbl_addr = (tbl_mode == ltd_pkg::TBL_MODE_PRE_INC) ? tp_inc : table_pointer;
    wire [20:0] tbl_tp = (tbl_mode == ltd_pkg::TBL_MODE_NONE) ? table_pointer :
        (tbl_mode == ltd_pkg::TBL_MODE_POST_DEC) ? tp_dec : tp_inc; // [RULE13] [RULE14]
    // a table instruction's own pointer update beats a datapath load
    wire [20:0] next_tp = tbl_start ? tbl_tp : tp_load ? tp_value : table_pointer;
    // no acknowledge by the last allowed cycle ends the access without data
    wire tbl_end = (state == ST_TABLE) && (pm_ack || (tbl_wait == ltd_pkg::TBL_WAIT_LIMIT));
    wire tbl_rd_ack = (state == ST_TABLE) && pm_ack && !pm.we;
    wire [7:0] next_latch = tbl_rd_ack ? pm_rdata : // [RULE13]
        lat_load ? lat_value : table_latch;
    ltd_pkg::ltd_pm_req_t pm_start;
    assign pm_start = '{req: 1'b1, we: tbl_write, addr: tbl_addr, wdata: table_latch}; // [RULE14]
    ltd_pkg::ltd_pm_req_t next_pm;
    assign next_pm = tbl_start ? pm_start : tbl_end ? ltd_pkg::PM_IDLE : pm;
    wire [2:0] next_wait = (state == ST_TABLE) ? 3'(tbl_wait + 3'h1) : 3'h0;

    assign instr_ready = ce && ((state == ST_EXEC) || (state == ST_PTR_SECOND));

    always_comb
    begin
        next_state = state;
        case (state)
            ST_EXEC:
            begin
                if (ret_now)
                    next_state = ST_EXTRA; // [RULE8]
                else if (ptr_long_start)
                    next_state = ST_PTR_SECOND; // [RULE10]
                else if (tbl_start)
                    next_state = ST_TABLE;
            end
            ST_EXTRA:
                next_state = ST_EXEC; // [RULE16]
            ST_PTR_SECOND:
            begin
                if (take)
                    next_state = ST_EXEC;
            end
            ST_TABLE:
            begin
                if (tbl_end)
                    next_state = ST_EXEC;
            end
            default:
                next_state = ST_EXEC;
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= ST_EXEC;
            working_register <= ltd_pkg::W_RESET;
            status <= ltd_pkg::STATUS_RESET;
            product <= ltd_pkg::PROD_RESET;
            bank_select_register <= ltd_pkg::BSR_RESET;
            ret_pulse <= 1'b0;
        end
        else if (ce)
        begin
            state <= next_state;
            working_register <= next_w;
            status <= next_status;
            product <= next_product;
            bank_select_register <= next_bsr;
            ret_pulse <= ret_now; // [RULE8]
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            ptr_sel <= 2'h0;
            ptr_hi <= 4'h0;
            table_pointer <= ltd_pkg::TP_RESET;
            table_latch <= ltd_pkg::LATCH_RESET;
            pm <= ltd_pkg::PM_IDLE;
            tbl_wait <= 3'h0;
        end
        else if (ce)
        begin
            if (ptr_long_start)
            begin
                ptr_sel <= instr[5:4];
                ptr_hi <= instr[3:0];
            end
            table_pointer <= next_tp;
            table_latch <= next_latch;
            pm <= next_pm;
            tbl_wait <= next_wait;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn || !ce);

    sequence seq_extra_nop;
        !instr_ready ##1 instr_ready;
    endsequence

    // the last wait edge ends the access, idle shows one edge later
    sequence seq_tbl_finish;
        pm.req ##[1:4] (state == ST_EXEC);
    endsequence

    AST_ADD_W: assert property (exec_now && op_hi == ltd_pkg::OP_ADD_LIT |=> // [RULE1]
        working_register == 8'($past(op_k) + $past(working_register)))
        else $error("add literal result wrong");
    AST_AND_FLAGS: assert property (exec_now && op_hi == ltd_pkg::OP_AND_LIT |=> // [RULE2]
        working_register == ($past(op_k) & $past(working_register))
        && status.c == $past(status.c) && status.ov == $past(status.ov))
        else $error("and literal wrong or touched c/ov");
    AST_IOR_W: assert property (exec_now && op_hi == ltd_pkg::OP_IOR_LIT |=> // [RULE3]
        working_register == ($past(op_k) | $past(working_register))
        && status.dc == $past(status.dc))
        else $error("or literal wrong");
    AST_XOR_W: assert property (exec_now && op_hi == ltd_pkg::OP_XOR_LIT |=> // [RULE4]
        working_register == ($past(op_k) ^ $past(working_register)))
        else $error("xor literal wrong");
    AST_SUB_W: assert property (exec_now && op_hi == ltd_pkg::OP_SUB_LIT |=> // [RULE5]
        working_register == 8'($past(op_k) - $past(working_register))
        && status.c == ($past(op_k) >= $past(working_register)))
        else $error("literal minus w wrong");
    AST_MOV_KEEP: assert property (exec_now && op_hi == ltd_pkg::OP_MOV_LIT |=> // [RULE6]
        working_register == $past(op_k) && status == $past(status))
        else $error("load literal wrong or flags moved");
    AST_MUL_PROD: assert property (exec_now && op_hi == ltd_pkg::OP_MUL_LIT |=> // [RULE7]
        product == 16'($past(op_k)) * 16'($past(working_register))
        && working_register == $past(working_register) && status == $past(status))
        else $error("multiply result wrong");
    AST_RET_TWO: assert property (ret_now |=> // [RULE8]
        ret_pulse && working_register == $past(op_k) ##0 seq_extra_nop)
        else $error("return with literal not two cycles");
    AST_BANK: assert property (exec_now && is_bank |=> // [RULE9]
        bank_select_register == $past(instr[5:0]) && status == $past(status))
        else $error("bank select load wrong");
    AST_PTR_LONG: assert property (ptr_long_start && instr[5:4] == 2'h1 ##1 ptr_long_done |=> // [RULE10]
        file_select_pointer[1] == {$past(ptr_hi), $past(instr[9:0])})
        else $error("long pointer load wrong");
    AST_PTR_ADD: assert property (ptr_add && instr[7:6] == 2'h0 |=> // [RULE11]
        file_select_pointer[0] == PTR_BITS'($past(file_select_pointer[0]) + $past(instr[5:0])))
        else $error("pointer add wrong");
    AST_PTR_SUB: assert property (ptr_sub && instr[7:6] == 2'h1 |=> // [RULE12]
        file_select_pointer[1] == PTR_BITS'($past(file_select_pointer[1]) - $past(instr[5:0])))
        else $error("pointer subtract wrong");
    AST_TBL_BOUND: assert property (tbl_start |=> seq_tbl_finish) // [RULE13] [RULE14]
        else $error("table access exceeded its cycle budget");
    AST_TBL_RD: assert property (tbl_rd_ack |=> table_latch == $past(pm_rdata)) // [RULE13]
        else $error("table read data not latched");
    AST_ORPHAN: assert property (take && state == ST_EXEC && is_second_word |=> // [RULE15]
        working_register == $past(working_register) && state == ST_EXEC && !pm.req)
        else $error("orphan second word had an effect");
    AST_ZN: assert property ((alu_op inside {ltd_pkg::ALU_ADD, ltd_pkg::ALU_SUB,
        ltd_pkg::ALU_AND, ltd_pkg::ALU_IOR, ltd_pkg::ALU_XOR}) |=> // [RULE17]
        status.z == (working_register == 8'h00) && status.n == working_register[7])
        else $error("zero or negative flag wrong");
endmodule

// file: bench/ltd_pm_model.sv
// program memory model answering table accesses after a set delay
`timescale 1ns/1ns
module ltd_pm_model (
    input wire logic clock,
    input wire logic rstn,
    input wire ltd_pkg::ltd_pm_req_t pm,
    input wire logic [2:0] delay,
    output logic pm_ack,
    output logic [7:0] pm_rdata
);
    logic [7:0] mem [256];
    logic [2:0] cnt;
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5a;
    end
    // delay above 2 runs past the device's wait window
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt <= 3'h0;
            pm_ack <= 1'b0;
            pm_rdata <= 8'h00;
        end
        else if (pm.req && !pm_ack && cnt == delay)
        begin
            pm_ack <= 1'b1;
            pm_rdata <= mem[pm.addr[7:0]];
            if (pm.we)
                mem[pm.addr[7:0]] <= pm.wdata;
        end
        else
        begin
            pm_ack <= 1'b0;
            // no stale data between answers
            pm_rdata <= ~pm_rdata;
            cnt <= (pm.req && !pm_ack) ? cnt + 3'h1 : 3'h0;
        end
    end
endmodule

// file: bench/literal_and_table_op_decoder_test.sv
// self-checking bench of the literal and table instruction decoder
`timescale 1ns/1ns
module literal_and_table_op_decoder_test;
    logic clock, rstn, ce, instr_valid, tp_load, lat_load;
    logic [15:0] instr;
    logic [20:0] tp_value;
    logic [7:0] lat_value;
    logic [2:0] delay;
    logic instr_ready, pm_ack, ret_pulse;
    logic [7:0] pm_rdata, working_register, table_latch;
    ltd_pkg::ltd_pm_req_t pm;
    ltd_pkg::ltd_status_t status;
    logic [5:0] bank_select_register;
    logic [2:0][13:0] file_select_pointer;
    logic [20:0] table_pointer;
    logic [15:0] product;
    int error_cnt, cmp_count, cyc;

    ltd_decoder DUT (.clock(clock), .rstn(rstn), .ce(ce), .instr_valid(instr_valid),
        .instr(instr), .instr_ready(instr_ready), .tp_load(tp_load), .tp_value(tp_value),
        .lat_load(lat_load), .lat_value(lat_value), .pm(pm), .pm_ack(pm_ack),
        .pm_rdata(pm_rdata), .working_register(working_register), .status(status),
        .bank_select_register(bank_select_register),
        .file_select_pointer(file_select_pointer), .table_pointer(table_pointer),
        .table_latch(table_latch), .product(product), .ret_pulse(ret_pulse));

    ltd_pm_model pm_model (.clock(clock), .rstn(rstn), .pm(pm), .delay(delay),
        .pm_ack(pm_ack), .pm_rdata(pm_rdata));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ends in the cycle after the taking edge, where results show
    task automatic issue(input logic [15:0] w);
        @(posedge clock);
        instr_valid <= 1'b1;
        instr <= w;
        @(negedge clock);
        while (instr_ready !== 1'b1)
            @(negedge clock);
        @(posedge clock);
        instr_valid <= 1'b0;
        @(negedge clock);
    endtask

    task automatic op_chk(input logic [15:0] w, input logic [7:0] ew, input logic [4:0] es);
        issue(w);
        chk(working_register, ew);
        chk(status, es);
    endtask

    task automatic t_literal();
        op_chk(16'h0ef0, 8'hf0, 5'h00);
        op_chk(16'h0f10, 8'h00, 5'h05);
        op_chk(16'h0e7f, 8'h7f, 5'h05);
        op_chk(16'h0f01, 8'h80, 5'h1a);
        op_chk(16'h0b0f, 8'h00, 5'h0e);
        op_chk(16'h0980, 8'h80, 5'h1a);
        op_chk(16'h0a80, 8'h00, 5'h0e);
        op_chk(16'h0e05, 8'h05, 5'h0e);
        op_chk(16'h0803, 8'hfe, 5'h10);
        op_chk(16'h0d03, 8'hfe, 5'h10);
        chk(product, 16'h02fa);
        issue(16'h013f);
        chk(bank_select_register, 6'h3f);
        // low bits differ so a load through a bad pad would show
        issue(16'h0141);
        chk(bank_select_register, 6'h3f);
    endtask

    task automatic t_return();
        op_chk(16'h0c55, 8'h55, 5'h10);
        chk(ret_pulse, 1'b1);
        chk(instr_ready, 1'b0);
        @(negedge clock);
        chk(ret_pulse, 1'b0);
        chk(instr_ready, 1'b1);
    endtask

    task automatic t_pointer();
        issue(16'hee12);
        issue(16'hf0ab);
        chk(file_select_pointer[1], 14'h08ab);
        issue(16'he87f);
        chk(file_select_pointer[1], 14'h08ea);
        issue(16'he941);
        chk(file_select_pointer[1], 14'h08e9);
        op_chk(16'hf123, 8'h55, 5'h10);
        chk(file_select_pointer[1], 14'h08e9);
        issue(16'he803);
        chk(file_select_pointer[0], 14'h0003);
    endtask

    // a word held while the enable is low is taken only once it returns
    task automatic t_freeze();
        @(posedge clock);
        ce <= 1'b0;
        instr_valid <= 1'b1;
        instr <= 16'h0e33;
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk(instr_ready, 1'b0);
        chk(working_register, 8'h55);
        @(posedge clock);
        ce <= 1'b1;
        @(posedge clock);
        instr_valid <= 1'b0;
        @(negedge clock);
        chk(working_register, 8'h33);
        chk(status, 5'h10);
    endtask

    // reads keep the latch when the answer is too late, writes keep memory only for a delay above 3
    task automatic tbl(input logic we, input logic [1:0] m, input logic [2:0] d);
        logic [20:0] a;
        logic [7:0] old;
        @(posedge clock);
        tp_load <= 1'b1;
        tp_value <= 21'h000100;
        lat_load <= 1'b1;
        lat_value <= 8'ha0 + 8'(m);
        delay <= d;
        @(posedge clock);
        tp_load <= 1'b0;
        lat_load <= 1'b0;
        a = (m == 2'h3) ? 21'h000101 : 21'h000100;
        old = pm_model.mem[a[7:0]];
        issue({12'h000, 1'b1, we, m});
        chk(instr_ready, 1'b0);
        chk(table_pointer, m == 2'h0 ? 21'h100 : m == 2'h2 ? 21'h0ff : 21'h101);
        chk(pm.addr, a);
        chk(pm.we, we);
        chk(pm.wdata, 8'ha0 + 8'(m));
        for (int i = 0; i < 4 && instr_ready !== 1'b1; i++)
            @(negedge clock);
        chk(instr_ready, 1'b1);
        chk(pm.req, 1'b0);
        // memory still sees a write that stands at the edge where the device gives up
        chk(we ? pm_model.mem[a[7:0]] : table_latch,
            (we ? d > 3'h3 : d <= 3'h2) ? old : 8'ha0 + 8'(m));
        chk(status, 5'h10);
    endtask

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    initial
    begin
        rstn = 1'b0;
        ce = 1'b1;
        instr_valid = 1'b0;
        instr = 16'h0000;
        tp_load = 1'b0;
        tp_value = 21'h000000;
        lat_load = 1'b0;
        lat_value = 8'h00;
        delay = 3'h0;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        t_literal();
        t_return();
        t_pointer();
        t_freeze();
        for (int m = 0; m < 4; m++)
        begin
            tbl(1'b0, 2'(m), m == 3 ? 3'h0 : 3'(m));
            tbl(1'b1, 2'(m), 3'(m));
        end
        tbl(1'b0, 2'h0, 3'h7);
        finish_test();
    end
endmodule
